// ==== hw/adc_seq_pkg.sv ====
// package for the converter measurement sequencer
package adc_seq_pkg;

  // configuration word location and field positions
  localparam logic [7:0] CFG_ADDR        = 8'h10;
  localparam int         BR_COARSE_LSB   = 6;
  localparam int         BR_FINE_LSB     = 8;
  localparam int         OFFSET_LSB      = 10;
  localparam int         TEMP_SEG_LSB    = 13;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // commands
  localparam logic [7:0] CMD_FULL_A      = 8'hAC;
  localparam logic [7:0] CMD_SINGLE_BR   = 8'hAA;  // single bridge conversion
  localparam logic [7:0] CMD_SINGLE_TEMP = 8'hAB;  // single temperature conversion

  // clock and typical conversion times in microseconds
  localparam int CLK_MHZ   = 125;
  localparam int T_10_0_US = 785;
  localparam int T_12_0_US = 3200;
  localparam int T_14_0_US = 12660;
  localparam int T_16_0_US = 49470;
  localparam int T_10_2_US = 830;
  localparam int T_12_2_US = 3240;
  localparam int T_14_2_US = 12710;
  localparam int T_10_4_US = 870;
  localparam int T_12_4_US = 3280;
  localparam int T_10_6_US = 940;
  localparam int T_OTHER_US = 940;  // segmentations outside the timed set

  // fixed temperature settings
  localparam logic [2:0] TEMP_OFFSET_FIXED = 3'h3;
  localparam logic [4:0] TEMP_GAIN_FIXED   = 5'h00;
  localparam logic [1:0] TEMP_SEG_FACTORY  = 2'h2;  // temperature code 00 maps to 10/6

  // one segmentation and offset setting for a conversion
  typedef struct packed {
    logic [1:0] coarseCode;  // 10,12,14,16 coarse bits
    logic [1:0] fineCode;    // 0,2,4,6 fine bits
    logic [2:0] offsetCode;
    logic [4:0] gainCode;
    logic       isTemp;
  } conv_setup_s;

  typedef enum logic [1:0] {
    STEP_BR_ZERO, STEP_BR, STEP_TEMP_ZERO, STEP_TEMP
  } step_e;

endpackage

// ==== hw/adc_measurement_sequencer.sv ====
// converter measurement sequencer: conversion timing, four-step run, correction, eoc
// Contract
// - Coarse-only conversions last 785, 3200, 12660 and 49470 us for 10 to 16 bits.
// - Mixed segmentations last 830, 3240, 12710, 870, 3280 and 940 us as tabulated.
// - A full result is built from zero-bridge, bridge, zero-temperature, temperature.
// - A full command lasts about 3.8 ms at 10/6 and 197.9 ms at 16/0.
// - The converter offset is a three-bit field at bits 12 to 10 of the config word.
// - Offset code n gives range -(n+1)/16 to (15-n)/16 of the reference.
// - Temperature conversions use fixed offset and gain, not the user fields.
// - Temperature segmentation follows the user temperature segmentation field.
// - The end-of-conversion pin rises when results are available.
// - In a full run, end of conversion is valid only after conversions and correction both finish.
// - After the conversions of a full command, the correction calculation is run by the processor.
// - Bridge coarse field bits 7:6 select 10, 12, 14 or 16 coarse bits.
// - Bridge fine field bits 9:8 select 0, 2, 4 or 6 fine bits.
// - Temperature field bits 14:13 give factory, 16/0, 10/6 or 12/4.
// - Command AC runs the four conversions in order, then the correction.
module adc_measurement_sequencer #(
  parameter int CLK_MHZ = adc_seq_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // command port from host interface
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdCode,
  output logic             cmdReady,
  // configuration word write from memory loader
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [15:0] cfgData,
  output logic [15:0]      measurementConfiguration,
  // analog front end control
  output logic             convActive,
  output logic [1:0]       convStep,
  output logic [1:0]       convCoarseCode,
  output logic [1:0]       convFineCode,
  output logic [2:0]       converterOffsetSelect,
  output logic [4:0]       convGainCode,
  // correction processor handshake
  output logic             corrStart,
  input  wire logic        corrDone,
  // end of conversion pin
  output logic             eocPin
);

  typedef enum logic [2:0] {IDLE, CONVERT, CORRECT, DONE} state_e;

  state_e                    state_ff, nxt_state;
  adc_seq_pkg::step_e        step_ff, nxt_step;
  logic                      full_ff, nxt_full;
  logic [31:0]               cnt_ff, nxt_cnt;
  logic [15:0]               cfg_ff, nxt_cfg;
  adc_seq_pkg::conv_setup_s  setup_ff, nxt_setup;
  logic                      eoc_ff, nxt_eoc;
  logic                      corrStart_ff, nxt_corrStart;
  adc_seq_pkg::conv_setup_s  brSetup, tempSetup;
  logic [1:0]                tSeg;
  logic [31:0]               convCycles;

  // conversion time in cycles from segmentation
  function automatic logic [31:0] cyclesFor(input logic [1:0] c, input logic [1:0] f);
    int us;
    us = adc_seq_pkg::T_OTHER_US;
    case ({c, f})
      4'h0: us = adc_seq_pkg::T_10_0_US;
      4'h4: us = adc_seq_pkg::T_12_0_US;
      4'h8: us = adc_seq_pkg::T_14_0_US;
      4'hC: us = adc_seq_pkg::T_16_0_US;
      4'h1: us = adc_seq_pkg::T_10_2_US;
      4'h5: us = adc_seq_pkg::T_12_2_US;
      4'h9: us = adc_seq_pkg::T_14_2_US;
      4'h2: us = adc_seq_pkg::T_10_4_US;
      4'h6: us = adc_seq_pkg::T_12_4_US;
      4'h3: us = adc_seq_pkg::T_10_6_US;
      default: us = adc_seq_pkg::T_OTHER_US;
    endcase
    return 32'(us * CLK_MHZ);
  endfunction

  // bridge and temperature setups decoded from the config word
  always_comb begin
    brSetup.coarseCode = cfg_ff[adc_seq_pkg::BR_COARSE_LSB +: 2];
    brSetup.fineCode   = cfg_ff[adc_seq_pkg::BR_FINE_LSB +: 2];
    brSetup.offsetCode = cfg_ff[adc_seq_pkg::OFFSET_LSB +: 3];
    brSetup.gainCode   = cfg_ff[4:0];
    brSetup.isTemp     = 1'b0;
    tSeg = cfg_ff[adc_seq_pkg::TEMP_SEG_LSB +: 2];
    if (tSeg == 2'h0) begin
      tSeg = adc_seq_pkg::TEMP_SEG_FACTORY;
    end
    case (tSeg)
      2'h1:    begin tempSetup.coarseCode = 2'h3; tempSetup.fineCode = 2'h0; end
      2'h2:    begin tempSetup.coarseCode = 2'h0; tempSetup.fineCode = 2'h3; end
      default: begin tempSetup.coarseCode = 2'h1; tempSetup.fineCode = 2'h2; end
    endcase
    tempSetup.offsetCode = adc_seq_pkg::TEMP_OFFSET_FIXED;
    tempSetup.gainCode   = adc_seq_pkg::TEMP_GAIN_FIXED;
    tempSetup.isTemp     = 1'b1;
  end

  assign convCycles = cyclesFor(setup_ff.coarseCode, setup_ff.fineCode);

  // sequencer next state
  always_comb begin
    nxt_state     = state_ff;
    nxt_step      = step_ff;
    nxt_full      = full_ff;
    nxt_cnt       = cnt_ff;
    nxt_setup     = setup_ff;
    nxt_eoc       = eoc_ff;
    nxt_corrStart = 1'b0;
    nxt_cfg       = cfg_ff;
    if (cfgWrite && cfgAddr == adc_seq_pkg::CFG_ADDR && state_ff != CONVERT) begin
      nxt_cfg = cfgData;
    end
    case (state_ff)
      IDLE, DONE: begin
        if (cmdValid) begin
          nxt_cnt = 32'h0;
          if (cmdCode == adc_seq_pkg::CMD_FULL_A) begin
            nxt_eoc   = 1'b0;  // only known codes drop the result flag
            nxt_full  = 1'b1;
            nxt_step  = adc_seq_pkg::STEP_BR_ZERO;
            nxt_setup = brSetup;
            nxt_state = CONVERT;
          end else if (cmdCode == adc_seq_pkg::CMD_SINGLE_BR) begin
            nxt_eoc   = 1'b0;
            nxt_full  = 1'b0;
            nxt_step  = adc_seq_pkg::STEP_BR;
            nxt_setup = brSetup;
            nxt_state = CONVERT;
          end else if (cmdCode == adc_seq_pkg::CMD_SINGLE_TEMP) begin
            nxt_eoc   = 1'b0;
            nxt_full  = 1'b0;
            nxt_step  = adc_seq_pkg::STEP_TEMP;
            nxt_setup = tempSetup;
            nxt_state = CONVERT;
          end
        end
      end
      CONVERT: begin
        nxt_cnt = cnt_ff + 32'h1;
        if (cnt_ff >= convCycles - 32'h1) begin
          nxt_cnt = 32'h0;
          if (full_ff && step_ff != adc_seq_pkg::STEP_TEMP) begin
            nxt_step = adc_seq_pkg::step_e'(step_ff + 2'h1);
            nxt_setup = (step_ff != adc_seq_pkg::STEP_BR_ZERO) ? tempSetup : brSetup;
          end else if (full_ff) begin
            nxt_state     = CORRECT;
            nxt_corrStart = 1'b1;
          end else begin
            nxt_state = DONE;
            nxt_eoc   = 1'b1;
          end
        end
      end
      CORRECT: begin
        if (corrDone) begin
          nxt_state = DONE;
          nxt_eoc   = 1'b1;
        end
      end
      default: nxt_state = IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= IDLE;
      step_ff      <= adc_seq_pkg::STEP_BR_ZERO;
      full_ff      <= 1'b0;
      cnt_ff       <= 32'h0;
      cfg_ff       <= adc_seq_pkg::CFG_RESET;
      setup_ff     <= '0;
      eoc_ff       <= 1'b0;
      corrStart_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      step_ff      <= nxt_step;
      full_ff      <= nxt_full;
      cnt_ff       <= nxt_cnt;
      cfg_ff       <= nxt_cfg;
      setup_ff     <= nxt_setup;
      eoc_ff       <= nxt_eoc;
      corrStart_ff <= nxt_corrStart;
    end
  end

  // outputs
  assign cmdReady                 = (state_ff == IDLE) || (state_ff == DONE);
  assign measurementConfiguration = cfg_ff;
  assign convActive               = (state_ff == CONVERT);
  assign convStep                 = step_ff;
  assign convCoarseCode           = setup_ff.coarseCode;
  assign convFineCode             = setup_ff.fineCode;
  assign converterOffsetSelect    = setup_ff.offsetCode;
  assign convGainCode             = setup_ff.gainCode;
  assign corrStart                = corrStart_ff;
  assign eocPin                   = eoc_ff;

  // eoc only after correction done in a full run
  eoc_after_corr_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == CORRECT && !corrDone) |=> !eocPin) else $error("eoc before correction");

  // setup held during a conversion
  setup_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && $past(convActive) && $stable(convStep)) |-> $stable(setup_ff))
    else $error("setup changed mid conversion");

  // temperature steps use fixed offset
  temp_offset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && convStep[1]) |-> converterOffsetSelect == adc_seq_pkg::TEMP_OFFSET_FIXED)
    else $error("temperature offset not fixed");

  // bridge steps use user offset
  bridge_offset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && !convStep[1] && $past(cmdValid && cmdReady))
    |-> converterOffsetSelect == $past(cfg_ff[12:10])) else $error("bridge offset wrong");

  // step order in full run
  step_order_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && $past(convActive) && full_ff && $changed(convStep))
    |-> convStep == $past(convStep) + 2'h1)
    else $error("step order wrong");

  // correction started after last step
  corr_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
    corrStart |-> (state_ff == CORRECT && $past(step_ff) == adc_seq_pkg::STEP_TEMP))
    else $error("correction start misplaced");

  // eoc rises only entering done
  eoc_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(eocPin) |-> state_ff == DONE) else $error("eoc rose outside done");

  // shortest conversion ends exactly on its count
  conv_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ($fell(convActive) && convCoarseCode == 2'h0 && convFineCode == 2'h0)
    |-> $past(cnt_ff) == 32'(adc_seq_pkg::T_10_0_US * CLK_MHZ) - 32'h1)
    else $error("shortest conversion length wrong");

  // named steps of a run, shared by the run assertions below
  sequence fullLaunch;
    cmdValid && cmdReady && cmdCode == adc_seq_pkg::CMD_FULL_A;
  endsequence

  sequence lastStepEnd;
    convActive && full_ff && step_ff == adc_seq_pkg::STEP_TEMP && cnt_ff >= convCycles - 32'h1;
  endsequence

  sequence singleEnd;
    convActive && !full_ff && cnt_ff >= convCycles - 32'h1;
  endsequence

  sequence corrFinish;
    state_ff == CORRECT && corrDone;
  endsequence

  // full command opens with the zero-bridge step
  full_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fullLaunch |=> (convActive && convStep == adc_seq_pkg::STEP_BR_ZERO && !eocPin))
    else $error("full run did not start at zero-bridge");

  // last temperature step hands over to correction
  corr_launch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    lastStepEnd |=> (corrStart && state_ff == CORRECT && !convActive))
    else $error("correction not launched after last step");

  // single conversion end shows the result on the next cycle
  single_eoc_a: assert property (@(posedge mclk) disable iff (!reset_n)
    singleEnd |=> (eocPin && !convActive))
    else $error("eoc missing after single conversion");

  // correction done gives eoc on the next cycle
  eoc_after_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    corrFinish |=> (eocPin && state_ff == DONE))
    else $error("eoc missing after correction");

  // correction start is a single pulse
  corr_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    corrStart |=> !corrStart)
    else $error("correction start longer than one cycle");

  // no result flag while converting or correcting
  eoc_busy_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive || state_ff == CORRECT) |-> !eocPin)
    else $error("eoc high while busy");

  // result flag stands until a new command
  eoc_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eocPin && !cmdValid) |=> eocPin)
    else $error("eoc dropped without command");

  // config word frozen while converting
  cfg_frozen_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && cfgWrite) |=> $stable(measurementConfiguration))
    else $error("config changed during conversion");

  // step stays put inside one conversion
  step_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (convActive && cnt_ff != 32'h0) |-> $stable(convStep))
    else $error("step changed mid conversion");

  // temperature steps carry the temperature setup
  temp_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    convActive |-> (setup_ff.isTemp == convStep[1]))
    else $error("setup kind does not match step");

endmodule

// ==== dv/corr_model.sv ====
// correction processor model: answers a start pulse after a set delay
module corr_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // handshake with the sequencer
  input  wire logic       corrStart,
  input  wire logic [3:0] delay,
  output logic            corrDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt;
  // count down after start, then one done pulse
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt  <= 0;
      corrDone <= 1'h0;
    end else begin
      corrDone <= (waitCnt == 1);
      if (corrStart) waitCnt <= delay + 2;
      else if (waitCnt > 0) waitCnt <= waitCnt - 1;
    end
  end
endmodule

// ==== dv/adc_measurement_sequencer_test.sv ====
// self-checking testbench of the measurement sequencer
module adc_measurement_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, reset_n = 1'h0, cmdValid = 1'h0, cfgWrite = 1'h0;
  logic        cmdReady, convActive, corrStart, corrDone, eocPin;
  logic [7:0]  cmdCode = 8'h00, cfgAddr = 8'h00;
  logic [15:0] cfgData = 16'h0000, measurementConfiguration, lfsr = 16'hBB91, cfg;
  logic [1:0]  convStep, convCoarseCode, convFineCode;
  logic [2:0]  converterOffsetSelect;
  logic [4:0]  convGainCode;
  logic [3:0]  delay = 4'h2;
  int          bad_count = 0, compares = 0;
  // free running clock, 8 ns
  always #4 mclk = ~mclk;
  adc_measurement_sequencer #(.CLK_MHZ(1)) adc_measurement_sequencer_inst (
    .mclk(mclk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdReady(cmdReady), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData),
    .measurementConfiguration(measurementConfiguration), .convActive(convActive),
    .convStep(convStep), .convCoarseCode(convCoarseCode), .convFineCode(convFineCode),
    .converterOffsetSelect(converterOffsetSelect), .convGainCode(convGainCode),
    .corrStart(corrStart), .corrDone(corrDone), .eocPin(eocPin));
  corr_model corr_model_inst (.mclk(mclk), .reset_n(reset_n), .corrStart(corrStart),
    .delay(delay), .corrDone(corrDone));
  // random source
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // typical conversion time per coarse and fine code
  function automatic int us(input logic [1:0] c, input logic [1:0] f);
    case ({c, f})
      4'h0: return 785;
      4'h4: return 3200;
      4'h8: return 12660;
      4'hC: return 49470;
      4'h1: return 830;
      4'h5: return 3240;
      4'h9: return 12710;
      4'h2: return 870;
      4'h6: return 3280;
      default: return 940;
    endcase
  endfunction
  // expected setup of a bridge or temperature conversion
  function automatic adc_seq_pkg::conv_setup_s want(input logic [15:0] c, input logic t);
    logic [1:0] s;
    s = (c[14:13] == 2'h0) ? adc_seq_pkg::TEMP_SEG_FACTORY : c[14:13];
    if (!t) return {c[7:6], c[9:8], c[12:10], c[4:0], 1'h0};
    return {(s == 2'h1) ? 2'h3 : (s == 2'h2) ? 2'h0 : 2'h1,
      (s == 2'h1) ? 2'h0 : (s == 2'h2) ? 2'h3 : 2'h2,
      adc_seq_pkg::TEMP_OFFSET_FIXED, adc_seq_pkg::TEMP_GAIN_FIXED, 1'h1};
  endfunction
  function automatic int dur(input logic [15:0] c, input logic t);
    adc_seq_pkg::conv_setup_s w;
    w = want(c, t);
    return us(w.coarseCode, w.fineCode);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_cfg(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] old;
    old = measurementConfiguration;
    cfgAddr = a;
    cfgData = d;
    cfgWrite = 1'h1;
    @(posedge mclk);
    #1 cfgWrite = 1'h0;
    @(posedge mclk);
    #1 chk(measurementConfiguration, (a == adc_seq_pkg::CFG_ADDR) ? d : old);
  endtask
  task automatic run(input logic [7:0] cmd);
    adc_seq_pkg::conv_setup_s w;
    int act, expN, corrs, last;
    logic done, full;
    full = (cmd == adc_seq_pkg::CMD_FULL_A);
    act = 0;
    corrs = 0;
    last = -1;
    done = 1'h0;
    expN = full ? 2 * dur(cfg, 1'h0) + 2 * dur(cfg, 1'h1) : dur(cfg, cmd[0]);
    cfgAddr = adc_seq_pkg::CFG_ADDR;
    cfgData = ~cfg;
    cmdCode = cmd;
    cmdValid = 1'h1;
    @(posedge mclk);
    #1 cmdValid = 1'h0;
    for (int i = 0; i < 60000 && eocPin !== 1'h1; i++) begin
      cfgWrite = (i == 3);  // write attempt inside the first conversion
      if (convActive === 1'h1) begin
        act++;
        w = want(cfg, convStep[1]);
        chk({convCoarseCode, convFineCode, converterOffsetSelect, convGainCode}, w[12:1]);
        if (full && convStep != last) chk(convStep, last + 1);
        last = convStep;
      end
      corrs += corrStart;
      done |= corrDone;
      @(posedge mclk);
      #1;
    end
    chk(eocPin, 1'h1);
    if (eocPin !== 1'h1) give_verdict();
    chk(measurementConfiguration, cfg);
    chk(act, expN);
    chk(corrs, full);
    chk(done, full);
    if (full) chk(last, 3);
  endtask
  // reset, corner cases, then random full runs
  initial begin
    repeat (12) @(posedge mclk);
    #1 reset_n = 1'h1;
    wr_cfg(8'h11, 16'h1234);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      cfg = {lfsr[15:10], i[1:0], 1'h0, i[2], lfsr[5:0]};
      wr_cfg(adc_seq_pkg::CFG_ADDR, cfg);
      run(adc_seq_pkg::CMD_SINGLE_BR);
    end
    for (int s = 0; s < 4; s++) begin
      lfsr = nxt(lfsr);
      cfg = {lfsr[15], s[1:0], lfsr[12:0]};  // all four codes, 16/0 included
      wr_cfg(adc_seq_pkg::CFG_ADDR, cfg);
      run(adc_seq_pkg::CMD_SINGLE_TEMP);
    end
    cmdCode = 8'h55;
    cmdValid = 1'h1;
    repeat (3) @(posedge mclk);
    #1 cmdValid = 1'h0;
    chk(convActive, 1'h0);
    chk(eocPin, 1'h1);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      delay = lfsr[3:0];
      cfg = {lfsr[15], lfsr[14], 1'h0, lfsr[12:8], 2'h0, lfsr[5:0]};  // temp 10/6 bounds run time
      wr_cfg(adc_seq_pkg::CFG_ADDR, cfg);
      run(adc_seq_pkg::CMD_FULL_A);
    end
    give_verdict();
  end
endmodule
